// ===== logic/sace_engine.sv
`timescale 1ns/100ps
// Notes on behaviour
// R1 - Word 164 bits 2:0 report I/O mode
// R2 - Word 164 bits 5:3 report memory mode
// R3 - Bits 8:6 give max I/O UDMA
// R4 - Bits 11:9 give max memory UDMA
// R5 - Bits 14:12 report selected UDMA mode
// R6 - Bit 15 flags UDMA support, qualifies fields
// R7 - Idle: busy, idle mode, unbusy, interrupt
// R8 - Nonzero count loads 5 ms power-down timer
// R9 - Zero count disables automatic power-down
// R10 - Without idle command, sleep after 20 ms
// R11 - Idle immediate keeps power-down timer unchanged
// R12 - Init parameters takes count and head
// R13 - NOP always ends command aborted
// R14 - Read buffer returns buffer by PIO
// R15 - DMA read count 1-256, zero is 256
// R16 - DMA start: busy, fill, request, unbusy
// R17 - DMA request held while data buffered
// R18 - Host acknowledges, strobes once per word
// R19 - DMA interrupts only at end or error
// R20 - Success leaves last sector address
// R21 - Error stops with failing sector address
// R22 - Eight-bit mode aborts DMA read
// R23 - PIO: busy, load, request, unbusy, interrupt
// R24 - LBA from head, cylinders, sector number
module sace_engine #(
    parameter int DEPTH = sace_pkg::SECTOR_WORDS,
    parameter int APD_TICK_CYC = sace_pkg::APD_UNIT_CYC,
    parameter logic [2:0] IO_MODE_MAX = 3'h0,
    parameter logic [2:0] MEM_MODE_MAX = 3'h0,
    parameter logic [2:0] IO_UDMA_MAX = 3'h0,
    parameter logic [2:0] MEM_UDMA_MAX = 3'h0,
    parameter logic UDMA_SUPPORTED = 1'b1
) (
    // Clock and reset
    input wire logic REF_CLK,
    input wire logic RST_B,
    // Register bus
    input wire sace_pkg::sace_axi_req_t AXI_REQ,
    output sace_pkg::sace_axi_rsp_t AXI_RSP,
    // Host pins
    output logic INTRQ,
    output logic DMA_REQUEST_LINE,
    input wire logic DMA_ACKNOWLEDGE_N,
    input wire logic IO_READ_STROBE_N,
    output logic [15:0] DMA_DATA,
    // Media side
    output logic MEDIA_REQ,
    output logic [27:0] MEDIA_LBA,
    input wire sace_pkg::sace_media_t MEDIA_IN,
    // Power
    output sace_pkg::sace_pwr_t POWER_STATE
);
    import sace_pkg::*;

    localparam int IW = $clog2(DEPTH);

    typedef struct packed {
        sace_axi_rsp_t rsp;
        logic aw_hit;
        logic [7:0] aw_addr;
        logic w_hit;
        logic [7:0] w_data;
        logic w_en;
        sace_state_t state;
        logic [7:0] cmd;
        logic [7:0] feat;
        logic [7:0] sc;
        logic [7:0] sn;
        logic [7:0] cyl_lo;
        logic [7:0] cyl_hi;
        logic [7:0] dh;
        logic busy;
        logic data_request_flag;
        logic err;
        logic abrt;
        logic unc;
        logic intrq;
        logic eight_bit;
        logic [2:0] udma_sel;
        logic [3:0] heads;
        logic [7:0] spt;
        sace_pwr_t pwr;
        logic idle_seen;
        logic apd_en;
        logic [7:0] apd_limit;
        logic [7:0] inact;
        logic [8:0] remaining;
        logic [27:0] lba;
        logic [IW-1:0] wr_idx;
        logic [IW-1:0] rd_idx;
        logic media_req;
        logic dma_req;
        logic [15:0] dma_data;
        logic io_read_strobe_n_prev;
        logic [DEPTH-1:0][15:0] buffer;
    } sace_eng_st_t;

    sace_eng_st_t st_ff;
    sace_eng_st_t nxt_st;

    logic [1:0] pins_s;
    logic tick;
    logic cmd_go;
    logic pio_pop;
    logic strobe_end;
    logic is_idle;
    logic is_imm;
    logic [31:0] rd;
    logic [7:0] status_byte;
    logic [7:0] err_byte;
    logic [15:0] word164;
    logic [27:0] lba_cur;
    logic [27:0] lba_next;

    sace_sync2 #(.W(2), .INIT(2'b11)) u_pin_sync (
        .clk(REF_CLK),
        .rst_b(RST_B),
        .d({DMA_ACKNOWLEDGE_N, IO_READ_STROBE_N}),
        .q(pins_s)
    );

    sace_tick_div #(.DIV(APD_TICK_CYC)) u_apd_tick (
        .clk(REF_CLK),
        .rst_b(RST_B),
        .tick(tick)
    );

    always_comb begin
        status_byte = '0;
        status_byte[STS_BUSY_BIT] = st_ff.busy;
        status_byte[STS_RDY_BIT] = !st_ff.busy;
        status_byte[STS_DRQ_BIT] = st_ff.data_request_flag;
        status_byte[STS_ERR_BIT] = st_ff.err;
        err_byte = '0;
        err_byte[ERR_UNC_BIT] = st_ff.unc;
        err_byte[ERR_ABRT_BIT] = st_ff.abrt;
        // UDMA fields read zero unless support is flagged
        word164 = {UDMA_SUPPORTED, // [R6]
                   UDMA_SUPPORTED ? st_ff.udma_sel : 3'h0, // [R5]
                   UDMA_SUPPORTED ? MEM_UDMA_MAX : 3'h0, // [R4]
                   UDMA_SUPPORTED ? IO_UDMA_MAX : 3'h0, // [R3]
                   MEM_MODE_MAX, // [R2]
                   IO_MODE_MAX}; // [R1]
        lba_cur = {st_ff.dh[3:0], st_ff.cyl_hi, st_ff.cyl_lo, st_ff.sn}; // [R24]
        lba_next = st_ff.lba + 28'h000_0001;
        is_idle = (st_ff.w_data == CMD_IDLE_A) || (st_ff.w_data == CMD_IDLE_B);
        is_imm = (st_ff.w_data == CMD_IMM_A) || (st_ff.w_data == CMD_IMM_B);
        strobe_end = pins_s[0] && !st_ff.io_read_strobe_n_prev && !pins_s[1]; // [R18]
    end

    always_comb begin
        nxt_st = st_ff;
        cmd_go = 1'b0;
        pio_pop = 1'b0;
        rd = '0;
        nxt_st.io_read_strobe_n_prev = pins_s[0];

        // Write channel: address and data taken in either order
        if (AXI_REQ.awvalid && st_ff.rsp.awready) begin
            nxt_st.aw_hit = 1'b1;
            nxt_st.aw_addr = AXI_REQ.awaddr;
        end
        if (AXI_REQ.wvalid && st_ff.rsp.wready) begin
            nxt_st.w_hit = 1'b1;
            nxt_st.w_data = AXI_REQ.wdata[7:0];
            nxt_st.w_en = AXI_REQ.wstrb[0];
        end
        if (st_ff.rsp.bvalid && AXI_REQ.bready) begin
            nxt_st.rsp.bvalid = 1'b0;
        end
        if (st_ff.aw_hit && st_ff.w_hit && !st_ff.rsp.bvalid) begin
            nxt_st.aw_hit = 1'b0;
            nxt_st.w_hit = 1'b0;
            nxt_st.rsp.bvalid = 1'b1;
            nxt_st.rsp.bresp = RESP_OKAY;
            // Task file is frozen only while busy is set, not in the DMA or PIO data phase
            if (st_ff.aw_addr == ADDR_FEAT) begin
                if (st_ff.w_en && !st_ff.busy) nxt_st.feat = st_ff.w_data;
            end else if (st_ff.aw_addr == ADDR_SCNT) begin
                if (st_ff.w_en && !st_ff.busy) nxt_st.sc = st_ff.w_data;
            end else if (st_ff.aw_addr == ADDR_SNUM) begin
                if (st_ff.w_en && !st_ff.busy) nxt_st.sn = st_ff.w_data;
            end else if (st_ff.aw_addr == ADDR_CYLO) begin
                if (st_ff.w_en && !st_ff.busy) nxt_st.cyl_lo = st_ff.w_data;
            end else if (st_ff.aw_addr == ADDR_CYHI) begin
                if (st_ff.w_en && !st_ff.busy) nxt_st.cyl_hi = st_ff.w_data;
            end else if (st_ff.aw_addr == ADDR_DRHD) begin
                if (st_ff.w_en && !st_ff.busy) nxt_st.dh = st_ff.w_data;
            end else if (st_ff.aw_addr == ADDR_CMD) begin
                cmd_go = st_ff.w_en && !st_ff.busy && !st_ff.data_request_flag;
            end else if (st_ff.aw_addr == ADDR_CFG) begin
                if (st_ff.w_en) begin
                    nxt_st.eight_bit = st_ff.w_data[CFG_8BIT_BIT];
                    if (st_ff.w_data[CFG_USEL_LSB +: 3] != UDMA_RESERVED) begin
                        nxt_st.udma_sel = st_ff.w_data[CFG_USEL_LSB +: 3];
                    end
                end
            end else begin
                nxt_st.rsp.bresp = RESP_SLVERR;
            end
        end

        // Read channel
        if (st_ff.rsp.rvalid && AXI_REQ.rready) begin
            nxt_st.rsp.rvalid = 1'b0;
            nxt_st.rsp.arready = 1'b1;
        end
        if (AXI_REQ.arvalid && st_ff.rsp.arready) begin
            nxt_st.rsp.arready = 1'b0;
            nxt_st.rsp.rvalid = 1'b1;
            nxt_st.rsp.rresp = RESP_OKAY;
            if (AXI_REQ.araddr == ADDR_DATA) begin
                rd[15:0] = st_ff.buffer[st_ff.rd_idx];
                pio_pop = (st_ff.state == ST_PIO);
            end else if (AXI_REQ.araddr == ADDR_FEAT) begin
                rd[7:0] = err_byte;
            end else if (AXI_REQ.araddr == ADDR_SCNT) begin
                rd[7:0] = st_ff.sc;
            end else if (AXI_REQ.araddr == ADDR_SNUM) begin
                rd[7:0] = st_ff.sn;
            end else if (AXI_REQ.araddr == ADDR_CYLO) begin
                rd[7:0] = st_ff.cyl_lo;
            end else if (AXI_REQ.araddr == ADDR_CYHI) begin
                rd[7:0] = st_ff.cyl_hi;
            end else if (AXI_REQ.araddr == ADDR_DRHD) begin
                rd[7:0] = st_ff.dh;
            end else if (AXI_REQ.araddr == ADDR_CMD) begin
                rd = {16'h0000, err_byte, status_byte};
                // Status read acknowledges the host interrupt
                nxt_st.intrq = 1'b0;
            end else if (AXI_REQ.araddr == ADDR_W164) begin
                rd[15:0] = word164;
            end else if (AXI_REQ.araddr == ADDR_CFG) begin
                rd[CFG_8BIT_BIT] = st_ff.eight_bit;
                rd[CFG_USEL_LSB +: 3] = st_ff.udma_sel;
            end else if (AXI_REQ.araddr == ADDR_GEOM) begin
                rd[11:0] = {st_ff.heads, st_ff.spt};
            end else if (AXI_REQ.araddr == ADDR_PWR) begin
                rd[20:0] = {st_ff.pwr, st_ff.idle_seen, st_ff.apd_en,
                            st_ff.apd_limit, st_ff.inact};
            end else begin
                nxt_st.rsp.rresp = RESP_SLVERR;
            end
            nxt_st.rsp.rdata = rd;
        end

        // Command sequencer
        case (st_ff.state)
            ST_READY: begin
                if (st_ff.busy) begin
                    nxt_st.busy = 1'b0; // [R7] [R11]
                    nxt_st.intrq = 1'b1; // [R7] [R11] [R23]
                    if (st_ff.cmd == CMD_RD_BUF) begin
                        nxt_st.state = ST_PIO; // [R14]
                        nxt_st.data_request_flag = 1'b1; // [R23]
                        nxt_st.rd_idx = '0;
                    end
                end
            end
            ST_FETCH: begin
                if (MEDIA_IN.err) begin
                    // Address registers already hold the failing sector
                    nxt_st.media_req = 1'b0; // [R21]
                    nxt_st.state = ST_READY;
                    nxt_st.busy = 1'b0;
                    nxt_st.err = 1'b1;
                    nxt_st.unc = 1'b1;
                    nxt_st.intrq = 1'b1; // [R19]
                end else if (MEDIA_IN.valid) begin
                    nxt_st.buffer[st_ff.wr_idx] = MEDIA_IN.word; // [R16]
                    nxt_st.wr_idx = st_ff.wr_idx + 1'b1;
                    if (&st_ff.wr_idx) begin
                        nxt_st.media_req = 1'b0;
                        nxt_st.state = ST_DMA;
                        nxt_st.dma_req = 1'b1; // [R17]
                        nxt_st.data_request_flag = 1'b1; // [R16]
                        nxt_st.busy = 1'b0; // [R16]
                        nxt_st.rd_idx = '0;
                    end
                end
            end
            ST_PIO: begin
                if (pio_pop) begin
                    nxt_st.rd_idx = st_ff.rd_idx + 1'b1;
                    if (&st_ff.rd_idx) begin
                        nxt_st.data_request_flag = 1'b0; // [R23]
                        nxt_st.state = ST_READY;
                    end
                end
            end
            ST_DMA: begin
                if (strobe_end) begin
                    nxt_st.rd_idx = st_ff.rd_idx + 1'b1; // [R18]
                    if (&st_ff.rd_idx) begin
                        nxt_st.dma_req = 1'b0; // [R17]
                        nxt_st.data_request_flag = 1'b0;
                        nxt_st.remaining = st_ff.remaining - 9'h001;
                        if (st_ff.remaining == 9'h001) begin
                            nxt_st.state = ST_READY; // [R20]
                            nxt_st.intrq = 1'b1; // [R19]
                        end else begin
                            nxt_st.lba = lba_next;
                            nxt_st.sn = lba_next[7:0];
                            nxt_st.cyl_lo = lba_next[15:8];
                            nxt_st.cyl_hi = lba_next[23:16];
                            nxt_st.dh[3:0] = lba_next[27:24];
                            nxt_st.state = ST_FETCH;
                            nxt_st.busy = 1'b1;
                            nxt_st.wr_idx = '0;
                            nxt_st.media_req = 1'b1;
                        end
                    end
                end
            end
            default: begin
                nxt_st.state = ST_READY;
            end
        endcase

        // Inactivity timer in 5 ms ticks
        if (tick && st_ff.state == ST_READY && !st_ff.busy &&
            !(&st_ff.inact)) begin
            nxt_st.inact = st_ff.inact + 8'h01;
        end
        if (st_ff.pwr != PWR_SLEEP && st_ff.state == ST_READY &&
            !st_ff.busy) begin
            if (st_ff.apd_en && st_ff.inact >= st_ff.apd_limit) begin
                nxt_st.pwr = PWR_SLEEP; // [R8]
            end
            if (!st_ff.idle_seen && st_ff.inact >= AUTO_SLEEP_TICKS) begin
                nxt_st.pwr = PWR_SLEEP; // [R10]
            end
        end

        if (cmd_go) begin
            nxt_st.cmd = st_ff.w_data;
            nxt_st.busy = 1'b1; // [R7] [R16] [R23]
            nxt_st.err = 1'b0;
            nxt_st.abrt = 1'b0;
            nxt_st.unc = 1'b0;
            nxt_st.inact = '0;
            nxt_st.pwr = PWR_ACTIVE;
            if (is_idle) begin
                nxt_st.pwr = PWR_IDLE; // [R7]
                nxt_st.idle_seen = 1'b1; // [R10]
                nxt_st.apd_en = (st_ff.sc != 8'h00); // [R8] [R9]
                if (st_ff.sc != 8'h00) nxt_st.apd_limit = st_ff.sc; // [R8]
            end else if (is_imm) begin
                nxt_st.pwr = PWR_IDLE; // [R11]
            end else if (st_ff.w_data == CMD_INIT_PARAM) begin
                nxt_st.spt = st_ff.sc; // [R12]
                nxt_st.heads = st_ff.dh[3:0]; // [R12]
            end else if (st_ff.w_data == CMD_RD_BUF) begin
                nxt_st.data_request_flag = 1'b0;
            end else if (st_ff.w_data == CMD_RD_DMA) begin
                if (st_ff.eight_bit) begin
                    nxt_st.err = 1'b1; // [R22]
                    nxt_st.abrt = 1'b1; // [R22]
                end else begin
                    nxt_st.remaining = (st_ff.sc == 8'h00) ?
                        SECTOR_MAX_CNT : {1'b0, st_ff.sc}; // [R15]
                    nxt_st.lba = lba_cur; // [R15] [R24]
                    nxt_st.state = ST_FETCH;
                    nxt_st.wr_idx = '0;
                    nxt_st.media_req = 1'b1;
                end
            end else begin
                // NOP and every code this engine does not run
                nxt_st.err = 1'b1; // [R13]
                nxt_st.abrt = 1'b1; // [R13]
            end
        end

        nxt_st.dma_data = st_ff.buffer[nxt_st.rd_idx];
        nxt_st.rsp.awready = !nxt_st.aw_hit && !nxt_st.rsp.bvalid;
        nxt_st.rsp.wready = !nxt_st.w_hit && !nxt_st.rsp.bvalid;
    end

    always_ff @(posedge REF_CLK or negedge RST_B) begin
        if (!RST_B) begin
            st_ff <= '0;
            st_ff.state <= ST_READY;
            st_ff.pwr <= PWR_ACTIVE;
            st_ff.rsp.awready <= 1'b1;
            st_ff.rsp.wready <= 1'b1;
            st_ff.rsp.arready <= 1'b1;
            st_ff.io_read_strobe_n_prev <= 1'b1;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign AXI_RSP = st_ff.rsp;
    assign INTRQ = st_ff.intrq;
    assign DMA_REQUEST_LINE = st_ff.dma_req;
    assign DMA_DATA = st_ff.dma_data;
    assign MEDIA_REQ = st_ff.media_req;
    assign MEDIA_LBA = st_ff.lba;
    assign POWER_STATE = st_ff.pwr;

    default clocking cb @(posedge REF_CLK);
    endclocking
    default disable iff (!RST_B);

    chk_idle_irq: assert property (cmd_go && is_idle |-> // [R7]
        ##2 (st_ff.intrq && !st_ff.busy && st_ff.pwr == PWR_IDLE))
        else $error("idle command did not finish with interrupt");
    chk_apd_load: assert property (cmd_go && is_idle && st_ff.sc != 0 // [R8]
        |=> st_ff.apd_en && st_ff.apd_limit == $past(st_ff.sc))
        else $error("power-down timer not loaded");
    chk_apd_off: assert property (cmd_go && is_idle && st_ff.sc == 0 // [R9]
        |=> !st_ff.apd_en)
        else $error("power-down not disabled by zero count");
    chk_immed_keep: assert property (cmd_go && is_imm |=> // [R11]
        $stable(st_ff.apd_limit) && $stable(st_ff.apd_en))
        else $error("idle immediate changed power-down timer");
    chk_nop_abort: assert property (cmd_go && st_ff.w_data == CMD_NOP // [R13]
        |-> ##2 (st_ff.err && st_ff.abrt && st_ff.intrq))
        else $error("nop did not abort");
    chk_dma_8bit: assert property (cmd_go && st_ff.eight_bit && // [R22]
        st_ff.w_data == CMD_RD_DMA |=> st_ff.abrt && !st_ff.media_req)
        else $error("dma read ran in eight-bit mode");
    chk_dma_request_line_src: assert property ($rose(st_ff.dma_req) |-> // [R17]
        $past(st_ff.state == ST_FETCH) && st_ff.state == ST_DMA)
        else $error("dma request without buffered sector");
    chk_sector_irq: assert property (st_ff.state == ST_DMA && // [R19]
        st_ff.remaining > 9'h001 |=> !$rose(st_ff.intrq))
        else $error("interrupt raised between sectors");
    chk_geom_load: assert property (cmd_go && // [R12]
        st_ff.w_data == CMD_INIT_PARAM |=> st_ff.spt == $past(st_ff.sc)
        && st_ff.heads == $past(st_ff.dh[3:0]))
        else $error("drive parameters not taken");

    cov_idle: cover property (cmd_go && is_idle);
    cov_dma_done: cover property (st_ff.state == ST_DMA
        ##1 st_ff.state == ST_READY && st_ff.intrq);
    cov_pio: cover property (st_ff.state == ST_PIO ##1 pio_pop);
    cov_sleep: cover property ($rose(st_ff.pwr == PWR_SLEEP));
endmodule : sace_engine

// ===== logic/sace_pkg.sv
package sace_pkg;
    // Clock and timing
    localparam int CLK_PERIOD_NS = 100;
    localparam int APD_UNIT_MS = 5;
    localparam int APD_UNIT_CYC = APD_UNIT_MS * 1_000_000 / CLK_PERIOD_NS;
    localparam int AUTO_SLEEP_MS = 20;
    localparam logic [7:0] AUTO_SLEEP_TICKS = 8'(AUTO_SLEEP_MS / APD_UNIT_MS);

    // Sector geometry
    localparam int SECTOR_WORDS = 256;
    localparam logic [8:0] SECTOR_MAX_CNT = 9'h100;

    // Command codes
    localparam logic [7:0] CMD_IDLE_A = 8'h97;
    localparam logic [7:0] CMD_IDLE_B = 8'hE3;
    localparam logic [7:0] CMD_IMM_A = 8'h95;
    localparam logic [7:0] CMD_IMM_B = 8'hE1;
    localparam logic [7:0] CMD_INIT_PARAM = 8'h91;
    localparam logic [7:0] CMD_NOP = 8'h00;
    localparam logic [7:0] CMD_RD_BUF = 8'hE4;
    localparam logic [7:0] CMD_RD_DMA = 8'hC8;

    // Register byte addresses
    localparam logic [7:0] ADDR_DATA = 8'h00;
    localparam logic [7:0] ADDR_FEAT = 8'h04;
    localparam logic [7:0] ADDR_SCNT = 8'h08;
    localparam logic [7:0] ADDR_SNUM = 8'h0C;
    localparam logic [7:0] ADDR_CYLO = 8'h10;
    localparam logic [7:0] ADDR_CYHI = 8'h14;
    localparam logic [7:0] ADDR_DRHD = 8'h18;
    localparam logic [7:0] ADDR_CMD = 8'h1C;
    localparam logic [7:0] ADDR_W164 = 8'h20;
    localparam logic [7:0] ADDR_CFG = 8'h24;
    localparam logic [7:0] ADDR_GEOM = 8'h28;
    localparam logic [7:0] ADDR_PWR = 8'h2C;

    // Field positions
    localparam int STS_BUSY_BIT = 7;
    localparam int STS_RDY_BIT = 6;
    localparam int STS_DRQ_BIT = 3;
    localparam int STS_ERR_BIT = 0;
    localparam int ERR_UNC_BIT = 6;
    localparam int ERR_ABRT_BIT = 2;
    localparam int CFG_8BIT_BIT = 0;
    localparam int CFG_USEL_LSB = 4;
    localparam logic [2:0] UDMA_RESERVED = 3'h7;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [3:0] {
        ST_READY = 4'b0001,
        ST_FETCH = 4'b0010,
        ST_PIO = 4'b0100,
        ST_DMA = 4'b1000
    } sace_state_t;

    typedef enum logic [2:0] {
        PWR_ACTIVE = 3'b001,
        PWR_IDLE = 3'b010,
        PWR_SLEEP = 3'b100
    } sace_pwr_t;

    typedef struct packed {
        logic awvalid;
        logic [7:0] awaddr;
        logic wvalid;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bready;
        logic arvalid;
        logic [7:0] araddr;
        logic rready;
    } sace_axi_req_t;

    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } sace_axi_rsp_t;

    typedef struct packed {
        logic valid;
        logic err;
        logic [15:0] word;
    } sace_media_t;
endpackage : sace_pkg

// ===== logic/sace_sync2.sv
`timescale 1ns/100ps
module sace_sync2 #(
    parameter int W = 1,
    parameter logic [W-1:0] INIT = '0
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } sace_sync_st_t;

    sace_sync_st_t st_ff;
    sace_sync_st_t nxt_st;

    always_comb begin
        nxt_st.s1 = d;
        nxt_st.s2 = st_ff.s1;
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            st_ff <= {INIT, INIT};
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign q = st_ff.s2;
endmodule : sace_sync2

// ===== logic/sace_tick_div.sv
`timescale 1ns/100ps
module sace_tick_div #(
    parameter int DIV = 50000
) (
    input wire logic clk,
    input wire logic rst_b,
    output logic tick
);
    localparam int CW = (DIV > 1) ? $clog2(DIV) : 1;
    localparam logic [CW-1:0] LAST = CW'(DIV - 1);

    typedef struct packed {
        logic [CW-1:0] cnt;
        logic tick;
    } sace_div_st_t;

    sace_div_st_t st_ff;
    sace_div_st_t nxt_st;

    always_comb begin
        nxt_st.tick = (st_ff.cnt == LAST);
        nxt_st.cnt = nxt_st.tick ? '0 : st_ff.cnt + 1'b1;
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign tick = st_ff.tick;
endmodule : sace_tick_div

// ===== tb/sace_host_dma.sv
`timescale 1ns/100ps
module sace_host_dma (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Link
    input wire logic dreq,
    input wire logic [15:0] data,
    output logic ack_n,
    output logic str_n,
    // Words seen out of sequence
    output logic [7:0] errs
);
    logic [2:0] ph;
    logic [8:0] cnt;
    // Strobe 4 cycles low, 4 high, only under acknowledge
    assign str_n = ack_n | ph[2];
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            ack_n <= 1'b1;
            ph <= 3'h0;
            cnt <= 9'h000;
            errs <= 8'h00;
        end else if (!ack_n) begin
            // A started word runs out even after the request drops
            ph <= ph + 3'h1;
            if (ph == 3'h3 && data != 16'(cnt) && !(&errs)) begin
                errs <= errs + 8'h01;
            end
            if (ph == 3'h7) begin
                cnt <= cnt + 9'h001;
                ack_n <= (cnt == 9'h0FF);
            end
        end else if (cnt == 9'h100) begin
            if (!dreq) cnt <= 9'h000;
        end else if (dreq) begin
            ack_n <= 1'b0;
        end
    end
endmodule : sace_host_dma

// ===== tb/sace_tb.sv
`timescale 1ns/100ps
module storage_card_ata_command_engine_tb_top;
    import sace_pkg::*;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    sace_axi_req_t req = '0;
    sace_axi_rsp_t rsp;
    sace_media_t med = '0;
    logic irq, dreq, ack_n, str_n, mreq;
    logic [27:0] lba;
    logic [8:0] mw = 9'h000;
    logic merr = 1'b0;
    logic [15:0] ddat;
    logic [7:0] errs;
    sace_pwr_t pwr;
    logic [31:0] rd;
    logic [7:0] ic [4] = '{CMD_IDLE_A, CMD_IMM_A, CMD_IMM_B, CMD_IDLE_B};
    int miscompares = 0;
    int total_checks = 0;
    always #50 clk = ~clk;
    sace_engine #(.APD_TICK_CYC(10), .IO_MODE_MAX(3'h3),
        .MEM_MODE_MAX(3'h2), .IO_UDMA_MAX(3'h4), .MEM_UDMA_MAX(3'h6))
    dut_u (.REF_CLK(clk), .RST_B(rst_b), .AXI_REQ(req), .AXI_RSP(rsp),
        .INTRQ(irq), .DMA_REQUEST_LINE(dreq), .DMA_ACKNOWLEDGE_N(ack_n),
        .IO_READ_STROBE_N(str_n), .DMA_DATA(ddat), .MEDIA_REQ(mreq),
        .MEDIA_LBA(lba), .MEDIA_IN(med), .POWER_STATE(pwr));
    sace_host_dma host_u (.clk(clk), .rst_b(rst_b), .dreq(dreq),
        .ack_n(ack_n), .str_n(str_n), .data(ddat), .errs(errs));
    // Media hands over one sector, a word a cycle, word k holding k
    always @(posedge clk) begin
        med.valid <= mreq && (mw + 9'(med.valid) < 9'h100);
        med.word <= 16'(mw + 9'(med.valid));
        med.err <= merr && mreq;
        mw <= mreq ? mw + 9'(med.valid) : 9'h000;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask : chk
    task automatic end_sim();
        $display("checks %0d miscompares %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : end_sim
    task automatic tick(inout int n);
        @(posedge clk);
        n++;
        if (n > 30000) begin
            miscompares++;
            $display("unexpected at %0t: timeout", $time);
            end_sim();
        end
    endtask : tick
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        int n = 0;
        @(posedge clk);
        req.awaddr <= a;
        req.wdata <= d;
        req.wstrb <= 4'hF;
        req.awvalid <= 1'b1;
        req.wvalid <= 1'b1;
        req.bready <= 1'b1;
        do begin
            tick(n);
            if (rsp.awready) req.awvalid <= 1'b0;
            if (rsp.wready) req.wvalid <= 1'b0;
        end while (!rsp.bvalid);
        req.bready <= 1'b0;
    endtask : wr
    task automatic rdr(input logic [7:0] a);
        int n = 0;
        @(posedge clk);
        req.araddr <= a;
        req.arvalid <= 1'b1;
        req.rready <= 1'b1;
        do begin
            tick(n);
            if (rsp.arready) req.arvalid <= 1'b0;
        end while (!rsp.rvalid);
        rd = rsp.rdata;
        req.rready <= 1'b0;
    endtask : rdr
    task automatic cmd(input logic [7:0] c);
        int n = 0;
        wr(ADDR_CMD, 32'(c));
        while (irq !== 1'b1) tick(n);
    endtask : cmd
    initial begin
        repeat (16) @(posedge clk);
        rst_b <= 1'b1;
        repeat (80) @(posedge clk);
        chk(32'(pwr), 32'(PWR_SLEEP));
        wr(ADDR_CFG, 32'h0000_0050);
        wr(ADDR_CFG, 32'h0000_0070);
        rdr(ADDR_W164);
        chk(32'(rd[15:0]), 32'h0000_DD13);
        $display("word164 end");
        for (int i = 0; i < 2; i++) begin
            wr(ADDR_CFG, 32'h0000_0050 | 32'(i));
            cmd(i ? CMD_RD_DMA : CMD_NOP);
            rdr(ADDR_CMD);
            chk(32'({rd[10], rd[0], rd[7], mreq}), 32'h0000_000C);
        end
        wr(ADDR_CFG, 32'h0000_0050);
        wr(ADDR_SCNT, 32'h0000_003F);
        wr(ADDR_DRHD, 32'h0000_0005);
        cmd(CMD_INIT_PARAM);
        rdr(ADDR_CMD);
        rdr(ADDR_GEOM);
        chk(32'(rd[11:0]), 32'h0000_053F);
        $display("abort and geometry end");
        for (int i = 0; i < 4; i++) begin
            wr(ADDR_SCNT, i ? 32'h0000_0000 : 32'h0000_0003);
            cmd(ic[i]);
            chk(32'(pwr), 32'(PWR_IDLE));
            rdr(ADDR_CMD);
            rdr(ADDR_PWR);
            chk(32'(rd[16:8]) >> (i / 3 * 8), i < 3 ? 32'h0000_0103 : 32'h0);
        end
        $display("idle end");
        wr(ADDR_SCNT, 32'h0000_0002);
        wr(ADDR_DRHD, 32'h0000_00E1);
        wr(ADDR_CYHI, 32'h0000_0022);
        wr(ADDR_CYLO, 32'h0000_0033);
        wr(ADDR_SNUM, 32'h0000_0044);
        cmd(CMD_RD_DMA);
        chk(32'({lba, dreq}), 32'h0244_668A);
        rdr(ADDR_SNUM);
        chk(rd, 32'h0000_0045);
        chk(32'(errs), 32'h0);
        $display("dma end");
        rdr(ADDR_CMD);
        cmd(CMD_RD_BUF);
        rdr(ADDR_CMD);
        chk(32'(rd[7:0]), 32'h0000_0048);
        for (int k = 0; k < 256; k++) begin
            rdr(ADDR_DATA);
            chk(rd, 32'(k));
        end
        rdr(ADDR_CMD);
        chk(32'(rd[7:0]), 32'h0000_0040);
        merr <= 1'b1;
        cmd(CMD_RD_DMA);
        merr <= 1'b0;
        rdr(ADDR_CMD);
        chk(32'({rd[14], rd[0], lba}), 32'h3122_3345);
        $display("buffer and error end");
        end_sim();
    end
endmodule : storage_card_ata_command_engine_tb_top
